// File: hw/ssf_top.sv
/*
  Sensor sample FIFO with off, normal, interrupt and snapshot modes,
  registers on a classic Wishbone slave.
  Assumes odrTick is a one-cycle pulse and samples are valid with it.
*/
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module ssf_top
  import ssf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  odrTick,
  input  wire ssf_sample_s           sampleIn,
  input  wire logic                  rateIntOr,
  input  wire logic                  rateIntAnd,
  output logic                       irq
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // ****************************************
  // state
  // ****************************************
  ssf_sample_s          mem [DEPTH];
  logic [PW-1:0]        wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [CW-1:0]        count_ff, nxt_count;
  logic                 lock_ff, nxt_lock;
  logic                 fifoOn_ff, nxt_fifoOn;
  logic                 snapTrig_ff, nxt_snapTrig;
  ssf_mode_e            mode_ff, nxt_mode;
  logic                 ovr_ff, nxt_ovr;
  ssf_sample_s          latest_ff, nxt_latest;
  logic [IRQ_WIDTH-1:0] irqStat_ff, nxt_irqStat, irqMask_ff, nxt_irqMask;
  logic [31:0]          datOut_ff, nxt_datOut;
  logic                 ack_ff, nxt_ack, irq_ff, nxt_irq;

  logic                 access, wrAcc, rdAcc, doPop, doPush, trigger;
  logic                 storing, overrunOn, fullNow;
  logic [IRQ_WIDTH-1:0] events;
  logic [CW-1:0]        cntAfterPop;

  function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
    ptrInc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptrInc

  function automatic logic [31:0] maskWrite(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    maskWrite = r;
  endfunction : maskWrite

  // ****************************************
  // bus decode
  // ****************************************
  assign access  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wrAcc   = access && wb_we_i;
  assign rdAcc   = access && !wb_we_i;
  assign trigger = rateIntOr || rateIntAnd;

  // ****************************************
  // fifo control
  // ****************************************
  always_comb begin
    logic [31:0] ctrlW;
    ctrlW        = maskWrite({29'h0, ovr_ff, mode_ff}, wb_dat_i, wb_sel_i);
    nxt_mode     = mode_ff;
    nxt_ovr      = ovr_ff;
    nxt_fifoOn   = fifoOn_ff;
    nxt_snapTrig = snapTrig_ff;
    if (wrAcc && wb_adr_i == ADDR_CTRL) begin
      nxt_mode     = ssf_mode_e'(ctrlW[CTRL_MODE_LSB +: 2]);
      nxt_ovr      = ctrlW[CTRL_OVR_BIT];
      nxt_fifoOn   = 1'b0;
      nxt_snapTrig = 1'b0;
    end else begin
      if (mode_ff == MODE_INTR && trigger) begin
        nxt_fifoOn = 1'b1;
      end
      if (mode_ff == MODE_SNAP && trigger) begin
        nxt_snapTrig = 1'b1;
      end
    end
  end

  always_comb begin
    storing   = (mode_ff == MODE_NORMAL) || (mode_ff == MODE_SNAP)
              || (mode_ff == MODE_INTR && fifoOn_ff);
    overrunOn = (mode_ff == MODE_SNAP) ? !snapTrig_ff : ovr_ff;
    doPop     = rdAcc && wb_adr_i == ADDR_DATA && count_ff != '0 && mode_ff != MODE_OFF;
    cntAfterPop = doPop ? count_ff - CW'(1) : count_ff;
    fullNow   = cntAfterPop == DEPTH_C;
    doPush    = odrTick && storing && !(lock_ff && !overrunOn) && (!fullNow || overrunOn);
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = doPop ? ptrInc(rdPtr_ff) : rdPtr_ff;
    nxt_count = cntAfterPop;
    nxt_lock  = lock_ff;
    events    = '0;
    if (odrTick) begin
      events[IRQ_READY_BIT] = 1'b1;
    end
    if (doPush) begin
      nxt_wrPtr = ptrInc(wrPtr_ff);
      if (fullNow) begin
        nxt_rdPtr = ptrInc(wrPtr_ff);
        events[IRQ_LOST_BIT] = 1'b1;
      end else begin
        nxt_count = cntAfterPop + CW'(1);
        if (cntAfterPop + CW'(1) == DEPTH_C) begin
          events[IRQ_FULL_BIT] = 1'b1;
        end
      end
    end else if (odrTick && storing) begin
      events[IRQ_LOST_BIT] = 1'b1;
    end
    if (!overrunOn && nxt_count == DEPTH_C) begin
      nxt_lock = 1'b1;
    end else if (nxt_count == '0 || overrunOn) begin
      nxt_lock = 1'b0;
    end
    if (mode_ff == MODE_OFF) begin
      nxt_count = '0;
      nxt_rdPtr = '0;
      nxt_wrPtr = '0;
      nxt_lock  = 1'b0;
    end
    nxt_latest = odrTick ? sampleIn : latest_ff;
  end

  // ****************************************
  // interrupt and bus answer
  // ****************************************
  always_comb begin
    logic [31:0] maskW;
    maskW       = maskWrite({29'h0, irqMask_ff}, wb_dat_i, wb_sel_i);
    nxt_irqStat = irqStat_ff;
    nxt_irqMask = irqMask_ff;
    if (wrAcc && wb_adr_i == ADDR_IRQSTAT && wb_sel_i[0]) begin
      nxt_irqStat = irqStat_ff & ~wb_dat_i[IRQ_WIDTH-1:0];
    end
    if (wrAcc && wb_adr_i == ADDR_IRQMASK) begin
      nxt_irqMask = maskW[IRQ_WIDTH-1:0];
    end
    nxt_irqStat = nxt_irqStat | events;
    nxt_irq     = |(nxt_irqStat & nxt_irqMask);
    nxt_ack     = access;
    nxt_datOut  = datOut_ff;
    if (rdAcc) begin
      if (wb_adr_i == ADDR_CTRL) begin
        nxt_datOut = {29'h0, ovr_ff, mode_ff};
      end else if (wb_adr_i == ADDR_STATUS) begin
        nxt_datOut = 32'h0000_0000;
        nxt_datOut[STAT_CNT_LSB +: CW] = count_ff;
        nxt_datOut[STAT_FULL_BIT] = count_ff == DEPTH_C;
        nxt_datOut[STAT_LOCK_BIT] = lock_ff;
        nxt_datOut[STAT_ON_BIT]   = storing;
        nxt_datOut[STAT_TRIG_BIT] = snapTrig_ff || fifoOn_ff;
      end else if (wb_adr_i == ADDR_DATA) begin
        nxt_datOut = doPop ? mem[rdPtr_ff] : 32'h0000_0000;
      end else if (wb_adr_i == ADDR_LATEST) begin
        nxt_datOut = latest_ff;
      end else if (wb_adr_i == ADDR_IRQSTAT) begin
        nxt_datOut = {29'h0, irqStat_ff};
      end else if (wb_adr_i == ADDR_IRQMASK) begin
        nxt_datOut = {29'h0, irqMask_ff};
      end else begin
        nxt_datOut = 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= sampleIn;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_ff    <= '0;
      rdPtr_ff    <= '0;
      count_ff    <= '0;
      lock_ff     <= 1'b0;
      fifoOn_ff   <= 1'b0;
      snapTrig_ff <= 1'b0;
      mode_ff     <= ssf_mode_e'(CTRL_RESET[1:0]);
      ovr_ff      <= CTRL_RESET[CTRL_OVR_BIT];
      latest_ff   <= '0;
      irqStat_ff  <= IRQ_RESET;
      irqMask_ff  <= IRQ_RESET;
      datOut_ff   <= 32'h0000_0000;
      ack_ff      <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      wrPtr_ff    <= nxt_wrPtr;
      rdPtr_ff    <= nxt_rdPtr;
      count_ff    <= nxt_count;
      lock_ff     <= nxt_lock;
      fifoOn_ff   <= nxt_fifoOn;
      snapTrig_ff <= nxt_snapTrig;
      mode_ff     <= nxt_mode;
      ovr_ff      <= nxt_ovr;
      latest_ff   <= nxt_latest;
      irqStat_ff  <= nxt_irqStat;
      irqMask_ff  <= nxt_irqMask;
      datOut_ff   <= nxt_datOut;
      ack_ff      <= nxt_ack;
      irq_ff      <= nxt_irq;
    end
  end

  assign wb_dat_o = datOut_ff;
  assign wb_ack_o = ack_ff;
  assign irq      = irq_ff;
endmodule : ssf_top

// File: common/ssf_pkg.sv
/*
  Constants and types for the sensor sample FIFO.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
// Functional notes
// - Normal mode pushes one sample set into the buffer on every rate tick.
// - Without overrun a full buffer drops every new sample.
// - Once full without overrun, storing stays blocked until buffer fully read.
// - Buffer-full event can raise an interrupt in every storing mode.
// - With overrun a full buffer overwrites its oldest entry, never stalls.
// - On overrun the read pointer is forced one lap behind the write pointer.
// - Interrupt mode starts with buffer off; samples reach data registers only.
// - In interrupt mode a rate interrupt turns the buffer on automatically.
// - Snapshot mode starts as normal mode with overrun enabled.
// - Snapshot rate interrupt switches to non-overrun and fills until full.
// - Buffer holds 256 entries of 16 bits per output channel.
// - Off mode keeps samples in data registers only; buffer reads return nothing.
// - Each buffer status flag can be individually enabled as an interrupt source.
package ssf_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_DATA     = 8'h08;
  localparam logic [7:0] ADDR_LATEST   = 8'h0C;
  localparam logic [7:0] ADDR_IRQSTAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQMASK  = 8'h14;
  localparam int         ADDR_WIDTH    = 8;

  // ****************************************
  // fields
  // ****************************************
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_OVR_BIT   = 2;
  localparam int STAT_CNT_LSB   = 0;
  localparam int STAT_FULL_BIT  = 16;
  localparam int STAT_LOCK_BIT  = 17;
  localparam int STAT_ON_BIT    = 18;
  localparam int STAT_TRIG_BIT  = 19;
  localparam int IRQ_FULL_BIT   = 0;
  localparam int IRQ_LOST_BIT   = 1;
  localparam int IRQ_READY_BIT  = 2;
  localparam int IRQ_WIDTH      = 3;

  localparam int          FIFO_DEPTH  = 256;
  localparam int          CHAN_WIDTH  = 16;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [2:0]  IRQ_RESET   = 3'h0;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_NORMAL,
    MODE_INTR,
    MODE_SNAP
  } ssf_mode_e;

  typedef struct packed {
    logic [CHAN_WIDTH-1:0] pitch;
    logic [CHAN_WIDTH-1:0] yaw;
  } ssf_sample_s;
endpackage : ssf_pkg

// File: sim/ssf_checker.sv
/* port checks for ssf_top.
   bound from the bench top, sees ports only. */
`timescale 1ns/1ns
module ssf_checker
  import ssf_pkg::*;
#(parameter int DEPTH = FIFO_DEPTH)
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  odrTick,
  input wire logic                  irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire req = wb_cyc_i && wb_stb_i;
  wire rdAck = wb_ack_o && !wb_we_i;
  ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (!req |=> !wb_ack_o) else $error("stray ack");
  reset_quiet_a: assert property ($fell(rst) |-> !irq && !wb_ack_o && wb_dat_o == 0) else $error("reset value");
  irq_rise_a: assert property ($rose(irq) |-> $past(odrTick) || (wb_ack_o && wb_we_i))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> wb_ack_o && wb_we_i) else $error("irq fell");
  read_hold_a: assert property ($changed(wb_dat_o) |-> rdAck || $past(rst)) else $error("data moved");
  unmapped_zero_a: assert property (rdAck && wb_adr_i > ADDR_IRQMASK |-> wb_dat_o == 0) else $error("unmapped");
  count_bound_a: assert property (rdAck && wb_adr_i == ADDR_STATUS |-> wb_dat_o[8:0] <= DEPTH &&
    wb_dat_o[STAT_FULL_BIT] == (wb_dat_o[8:0] == DEPTH)) else $error("bad count");
endmodule : ssf_checker

// File: sim/ssf_sensor_model.sv
/* sensor side model: a burst of rate ticks with random gaps.
   assumes go is a one-cycle pulse while idle. */
`timescale 1ns/1ns
module ssf_sensor_model
  import ssf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [7:0] burst,
  output logic            busy,
  output logic            odrTick = 1'b0,
  output ssf_sample_s     sampleIn = '0
);
  logic [7:0] left = 0;
  logic [1:0] gap = 0;
  assign busy = left != 0 || odrTick;
  always @(posedge clk) begin
    odrTick <= 1'b0;
    // no valid sample: keep it moving
    sampleIn <= ~sampleIn;
    if (rst) begin
      left <= 0;
    end else if (go) begin
      left <= burst;
    end else if (left != 0 && gap == 0) begin
      odrTick <= 1'b1;
      sampleIn <= $urandom;
      left <= left - 1;
      gap <= $urandom_range(3, 0);
    end else if (gap != 0) begin
      gap <= gap - 1;
    end
  end
endmodule : ssf_sensor_model

// File: sim/ssf_top_tb_top.sv
/* bench top: host side of ssf_top against a queue model.
   assumes the sensor model supplies ticks only when asked. */
`timescale 1ns/1ns
module ssf_top_tb_top;
  import ssf_pkg::*;
  localparam int D = 4;
  logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, rateIntOr = 0, rateIntAnd = 0, go = 0;
  logic [7:0] wb_adr_i = 0, burst = 0;
  logic [31:0] wb_dat_i = 0, r, lastS = 0;
  logic [31:0] wb_dat_o, q[$];
  logic wb_ack_o, irq, odrTick, busy, ovr = 0, trg = 0, lck = 0, ov;
  logic [2:0] st = 0, msk = 0;
  logic [1:0] md = 0;
  ssf_sample_s sampleIn;
  int fails = 0, checks = 0;
  always #10 clk = ~clk;
  ssf_top #(.DEPTH(D)) dut_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .odrTick(odrTick), .sampleIn(sampleIn), .rateIntOr(rateIntOr), .rateIntAnd(rateIntAnd), .irq(irq));
  ssf_sensor_model src_u (.clk(clk), .rst(rst), .go(go), .burst(burst), .busy(busy), .odrTick(odrTick),
    .sampleIn(sampleIn));
  // ****
  // reference model
  // ****
  always @(posedge clk) begin
    if (!rst && odrTick) begin
      lastS = sampleIn;
      st[IRQ_READY_BIT] = 1;
      ov = md == MODE_SNAP ? !trg : ovr;
      if (md == MODE_NORMAL || md == MODE_SNAP || (md == MODE_INTR && trg)) begin
        if (lck || (q.size() == D && !ov)) begin
          st[IRQ_LOST_BIT] = 1;
        end else if (q.size() == D) begin
          q = q[1:$];
          q.push_back(sampleIn);
          st[IRQ_LOST_BIT] = 1;
        end else begin
          if (q.size() == D - 1) begin
            st[IRQ_FULL_BIT] = 1;
            lck = !ov;
          end
          q.push_back(sampleIn);
        end
      end
    end
  end
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    if (n == 20)
      fails++;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1, a, d);
    if (a == ADDR_CTRL) begin
      md = d[1:0];
      ovr = d[CTRL_OVR_BIT];
      trg = 0;
      lck = 0;
      if (md == MODE_OFF)
        q = {};
    end
    if (a == ADDR_IRQSTAT)
      st = st & ~d[2:0];
    if (a == ADDR_IRQMASK)
      msk = d[2:0];
  endtask : wr
  task automatic rdm(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(0, a, 0);
    cmp(e, r & m);
  endtask : rdm
  task automatic pop();
    logic [31:0] e;
    e = q.size() ? q.pop_front() : 0;
    if (q.size() == 0)
      lck = 0;
    rdm(ADDR_DATA, e, '1);
  endtask : pop
  task automatic stat();
    logic [31:0] e;
    e = q.size();
    e[STAT_FULL_BIT] = q.size() == D;
    e[STAT_LOCK_BIT] = lck;
    e[STAT_ON_BIT] = md == MODE_NORMAL || md == MODE_SNAP || (md == MODE_INTR && trg);
    e[STAT_TRIG_BIT] = trg;
    rdm(ADDR_STATUS, e, 32'h000f_01ff);
  endtask : stat
  task automatic tick(input int n);
    int k;
    k = 0;
    go <= 1;
    burst <= n;
    @(posedge clk);
    go <= 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy && k < 200);
  endtask : tick
  task automatic scen(input logic [1:0] m, input logic o, input int n1, input int n2);
    wr(ADDR_CTRL, 0);
    wr(ADDR_IRQSTAT, 7);
    wr(ADDR_IRQMASK, $urandom);
    wr(ADDR_CTRL, {o, m});
    tick(n1);
    stat();
    pop();
    tick(2);
    stat();
    rateIntOr <= !n2[0];
    rateIntAnd <= n2[0];
    @(posedge clk);
    rateIntOr <= 0;
    rateIntAnd <= 0;
    @(posedge clk);
    if (md == MODE_INTR || md == MODE_SNAP)
      trg = 1;
    if (md == MODE_SNAP && q.size() == D)
      lck = 1;
    tick(n2);
    stat();
    rdm(ADDR_IRQSTAT, st, 7);
    cmp(|(st & msk), irq);
    while (q.size())
      pop();
    pop();
    tick(1);
    stat();
    rdm(ADDR_LATEST, lastS, '1);
    $display("test mode %0d ovr %0d done", m, o);
  endtask : scen
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(27));
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rdm(ADDR_IRQMASK, IRQ_RESET, '1);
    rdm(ADDR_CTRL, CTRL_RESET, '1);
    rdm(8'h18, 0, '1);
    scen(MODE_NORMAL, 0, 6, 1);
    scen(MODE_NORMAL, 1, 6, 2);
    scen(MODE_INTR, 0, 2, 3);
    scen(MODE_INTR, 1, 2, 7);
    scen(MODE_SNAP, 0, 6, 3);
    scen(MODE_OFF, 0, 3, 2);
    end_of_test();
  end
endmodule : ssf_top_tb_top
bind ssf_top ssf_checker #(.DEPTH(DEPTH)) chk_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .odrTick(odrTick), .irq(irq));
